// *** bpls_sequencer.sv ***
// Converter and lamp sequencer of a dimmable fluorescent ballast with its register port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Converter off idles until a nonzero setpoint write requests lamp on.
// RULE_02: Converter init moves unconditionally to input-check init on the next tick.
// RULE_03: Input measure records the rectified peak over the minimum check time.
// RULE_04: Peak within min and max sets pulse limit and goes on, else re-init.
// RULE_05: Soft-start config sets up converter PWM and comparator, then launch.
// RULE_06: Launch starts PWM if attempts below limit, else converter problem.
// RULE_07: Soft start rechecks attempts; under limit speed-up, else problem.
// RULE_08: Zero cross in speed-up runs converter, raises clock, enters zero-cross search.
// RULE_09: No zero cross in speed-up goes to retry delay.
// RULE_10: Retry delay waits delay times multiplier ticks, then reconfigures soft start.
// RULE_11: Zero-cross search waits for a crossing before entering closed-loop control.
// RULE_12: Shutdown stops converter, drops clock to low power, returns to off.
// RULE_13: Command logic forces shutdown whenever a shutdown command is written, from any converter state.
// RULE_14: Lamp stays off until converter reaches closed-loop control, then preheat config.
// RULE_15: Preheat config enables sense amplifier, sets inverter, clears lamp variables.
// RULE_16: Preheat runs inverter for preheat time, at 80 kHz first and at the restart half period after a restart, then ignition start.
// RULE_17: Ignition start lowers frequency down to the ignition half period.
// RULE_18: Ignition holds 10 ms, then judges strike from lamp current and voltage.
// RULE_19: Restart reloads restart parameters to preheat, or too-many-tries once failures reach limit.
// RULE_20: Run start raises frequency from the ignition setting, then run mode.
// RULE_21: Run mode regulates toward setpoint; setpoint zero returns lamp to off.
// RULE_22: Too many ignition failures set a flag that commands switch-off.
// RULE_23: Converter steps each 1 ms slow, each 200 us nominal; lamp each 200 us.
// RULE_24: Converter problem keeps PWM stopped until a shutdown request arrives.
module bpls_sequencer
   import bpls_pkg::*;
#(
   parameter int unsigned CONV_SLOW_CYC = BPLS_CONV_SLOW_CYC,
   parameter int unsigned CONV_FAST_CYC = BPLS_CONV_FAST_CYC,
   parameter int unsigned LAMP_TICK_CYC = BPLS_LAMP_TICK_CYC,
   parameter int unsigned PREHEAT_TICKS = BPLS_PREHEAT_TICKS
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [9:0] peak_sample_in,
   input wire logic zero_cross_in,
   input wire logic [9:0] lamp_current_in,
   input wire logic [9:0] lamp_voltage_in,
   output bpls_conv_drive_s conv_drive_out,
   output bpls_inv_drive_s inv_drive_out,
   output logic too_many_tries_out
);
   bpls_conv_e conv_state_ff;
   bpls_lamp_e lamp_state_ff;
   bpls_conv_drive_s conv_drive_ff;
   bpls_inv_drive_s inv_drive_ff;
   logic [9:0] setpoint_ff;
   logic [9:0] peak_min_ff;
   logic [9:0] peak_max_ff;
   logic [9:0] peak_ff;
   logic [31:0] rdata_ff;
   logic lamp_on_req_ff;
   logic zc_seen_ff;
   logic too_many_ff;
   logic [3:0] conv_tries_ff;
   logic [7:0] conv_tmr_ff;
   logic [3:0] ign_fail_ff;
   logic [12:0] lamp_tmr_ff;
   logic [14:0] conv_cnt_ff;
   logic [14:0] lamp_cnt_ff;
   logic conv_tick;
   logic lamp_tick;
   logic wr_setpoint;
   logic shut_req;
   logic [14:0] conv_limit;

   assign wr_setpoint = reg_wr_in && (reg_addr_in == BPLS_REG_SETPOINT);
   assign shut_req = reg_wr_in && (reg_addr_in == BPLS_REG_COMMAND) && reg_wdata_in[BPLS_CMD_SHUTDOWN_BIT];

   // Task tick dividers
   assign conv_limit = conv_drive_ff.clk_nominal ? 15'(CONV_FAST_CYC - 1) : 15'(CONV_SLOW_CYC - 1); // RULE_23
   assign conv_tick = (conv_cnt_ff == conv_limit); // RULE_23
   assign lamp_tick = (lamp_cnt_ff == 15'(LAMP_TICK_CYC - 1)); // RULE_23

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || conv_tick) begin
         conv_cnt_ff <= 15'h0000;
      end else begin
         conv_cnt_ff <= conv_cnt_ff + 15'h0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || lamp_tick) begin
         lamp_cnt_ff <= 15'h0000;
      end else begin
         lamp_cnt_ff <= lamp_cnt_ff + 15'h0001;
      end
   end

   // Register port
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         setpoint_ff <= 10'h000;
         peak_min_ff <= BPLS_PEAK_MIN_RST;
         peak_max_ff <= BPLS_PEAK_MAX_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == BPLS_REG_SETPOINT) begin
            setpoint_ff <= reg_wdata_in[9:0];
         end
         if (reg_addr_in == BPLS_REG_PEAK_MIN) begin
            peak_min_ff <= reg_wdata_in[9:0];
         end
         if (reg_addr_in == BPLS_REG_PEAK_MAX) begin
            peak_max_ff <= reg_wdata_in[9:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_ff <= 32'h00000000;
      end else if (reg_rd_in) begin
         rdata_ff <= 32'h00000000;
         unique case (reg_addr_in)
            BPLS_REG_SETPOINT: rdata_ff[9:0] <= setpoint_ff;
            BPLS_REG_PEAK_MIN: rdata_ff[9:0] <= peak_min_ff;
            BPLS_REG_PEAK_MAX: rdata_ff[9:0] <= peak_max_ff;
            BPLS_REG_PEAK: rdata_ff[9:0] <= peak_ff;
            BPLS_REG_STATUS: begin
               rdata_ff[BPLS_ST_CONV_LSB +: 4] <= conv_state_ff;
               rdata_ff[BPLS_ST_LAMP_LSB +: 4] <= lamp_state_ff;
               rdata_ff[BPLS_ST_TOO_MANY_BIT] <= too_many_ff;
               rdata_ff[BPLS_ST_NOMINAL_BIT] <= conv_drive_ff.clk_nominal;
               rdata_ff[BPLS_ST_TRIES_LSB +: 4] <= conv_tries_ff;
            end
            default: rdata_ff <= 32'h00000000;
         endcase
      end
   end
   assign reg_rdata_out = rdata_ff;

   // Lamp-on request; a new request wins over its consumption
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lamp_on_req_ff <= 1'b0;
      end else if (wr_setpoint && (reg_wdata_in[9:0] != 10'h000)) begin
         lamp_on_req_ff <= 1'b1; // RULE_01
      end else if (shut_req || (conv_tick && conv_state_ff == CONV_OFF)) begin
         lamp_on_req_ff <= 1'b0;
      end
   end

   // Zero-crossing latch, cleared when a tick consumes it; a new crossing wins
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         zc_seen_ff <= 1'b0;
      end else if (zero_cross_in) begin
         zc_seen_ff <= 1'b1;
      end else if (conv_tick) begin
         zc_seen_ff <= 1'b0;
      end
   end

   // Converter sequencer
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         conv_state_ff <= CONV_OFF;
         conv_drive_ff <= '0;
         conv_tries_ff <= 4'h0;
         conv_tmr_ff <= 8'h00;
         peak_ff <= 10'h000;
      end else if (shut_req) begin
         conv_state_ff <= CONV_SHUTDOWN; // RULE_13
      end else if (conv_tick) begin
         unique case (conv_state_ff)
            CONV_OFF: begin
               if (lamp_on_req_ff) begin
                  conv_state_ff <= CONV_INIT; // RULE_01
               end
            end
            CONV_INIT: conv_state_ff <= CONV_INIT_CHECK; // RULE_02
            CONV_INIT_CHECK: begin
               conv_drive_ff <= '0;
               conv_tries_ff <= 4'h0;
               conv_tmr_ff <= 8'h00;
               peak_ff <= 10'h000;
               conv_state_ff <= CONV_MEASURE; // RULE_02
            end
            CONV_MEASURE: begin
               if (peak_sample_in > peak_ff) begin
                  peak_ff <= peak_sample_in; // RULE_03
               end
               conv_tmr_ff <= conv_tmr_ff + 8'h01;
               if (conv_tmr_ff == BPLS_MEASURE_TICKS - 8'h01) begin
                  conv_state_ff <= CONV_CHECK; // RULE_03
               end
            end
            CONV_CHECK: begin
               if (peak_ff >= peak_min_ff && peak_ff <= peak_max_ff) begin
                  conv_drive_ff.max_pulse <= BPLS_MAX_PW; // RULE_04
                  conv_state_ff <= CONV_SS_CFG;
               end else begin
                  conv_state_ff <= CONV_INIT_CHECK; // RULE_04
               end
            end
            CONV_SS_CFG: begin
               conv_drive_ff.softstart_cfg <= 1'b1; // RULE_05
               conv_drive_ff.comparator_en <= 1'b1;
               conv_state_ff <= CONV_SS_LAUNCH;
            end
            CONV_SS_LAUNCH: begin
               if (conv_tries_ff < BPLS_CONV_MAX_TRIES) begin
                  conv_drive_ff.pwm_run <= 1'b1; // RULE_06
                  conv_state_ff <= CONV_SOFT_START;
               end else begin
                  conv_drive_ff.pwm_run <= 1'b0;
                  conv_state_ff <= CONV_PROBLEM; // RULE_06
               end
            end
            CONV_SOFT_START: begin
               if (conv_tries_ff < BPLS_CONV_MAX_TRIES) begin
                  conv_state_ff <= CONV_SPEED_UP; // RULE_07
               end else begin
                  conv_drive_ff.pwm_run <= 1'b0;
                  conv_state_ff <= CONV_PROBLEM; // RULE_07
               end
            end
            CONV_SPEED_UP: begin
               if (zc_seen_ff || zero_cross_in) begin
                  conv_drive_ff.softstart_cfg <= 1'b0; // RULE_08
                  conv_drive_ff.clk_nominal <= 1'b1;
                  conv_state_ff <= CONV_ZC_SEARCH;
               end else begin
                  conv_drive_ff.pwm_run <= 1'b0; // RULE_09
                  conv_tries_ff <= conv_tries_ff + 4'h1;
                  conv_tmr_ff <= 8'h00;
                  conv_state_ff <= CONV_RETRY_DELAY;
               end
            end
            CONV_RETRY_DELAY: begin
               conv_tmr_ff <= conv_tmr_ff + 8'h01;
               if (conv_tmr_ff == 8'(BPLS_RETRY_DELAY * BPLS_RETRY_MULT - 8'h01)) begin
                  conv_state_ff <= CONV_SS_CFG; // RULE_10
               end
            end
            CONV_ZC_SEARCH: begin
               if (zc_seen_ff || zero_cross_in) begin
                  conv_state_ff <= CONV_CTRL_LOOP; // RULE_11
               end
            end
            CONV_CTRL_LOOP: conv_state_ff <= CONV_CTRL_LOOP;
            CONV_PROBLEM: conv_drive_ff.pwm_run <= 1'b0; // RULE_24
            CONV_SHUTDOWN: begin
               conv_drive_ff <= '0; // RULE_12
               conv_state_ff <= CONV_OFF;
            end
            default: conv_state_ff <= CONV_SHUTDOWN;
         endcase
      end
   end
   assign conv_drive_out = conv_drive_ff;

   // Lamp sequencer
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lamp_state_ff <= LAMP_OFF;
         inv_drive_ff <= '0;
         ign_fail_ff <= 4'h0;
         lamp_tmr_ff <= 13'h0000;
      end else if (lamp_tick) begin
         if (lamp_state_ff != LAMP_OFF && lamp_state_ff != LAMP_TOO_MANY &&
             (setpoint_ff == 10'h000 || conv_state_ff != CONV_CTRL_LOOP)) begin
            inv_drive_ff <= '0; // RULE_21
            lamp_state_ff <= LAMP_OFF;
         end else begin
            unique case (lamp_state_ff)
               LAMP_OFF: begin
                  if (conv_state_ff == CONV_CTRL_LOOP) begin
                     lamp_state_ff <= LAMP_PRE_CFG; // RULE_14
                  end
               end
               LAMP_PRE_CFG: begin
                  inv_drive_ff.sense_amp_en <= 1'b1; // RULE_15
                  inv_drive_ff.half_period <= BPLS_PREHEAT_HP;
                  ign_fail_ff <= 4'h0;
                  lamp_tmr_ff <= 13'h0000;
                  lamp_state_ff <= LAMP_PREHEAT;
               end
               LAMP_PREHEAT: begin
                  inv_drive_ff.pwm_run <= 1'b1; // RULE_16
                  lamp_tmr_ff <= lamp_tmr_ff + 13'h0001;
                  if (lamp_tmr_ff == 13'(PREHEAT_TICKS - 1)) begin
                     lamp_tmr_ff <= 13'h0000;
                     lamp_state_ff <= LAMP_IGN_START; // RULE_16
                  end
               end
               LAMP_IGN_START: begin
                  if (inv_drive_ff.half_period < BPLS_IGN_HP) begin
                     inv_drive_ff.half_period <= inv_drive_ff.half_period + 8'h01; // RULE_17
                  end else begin
                     lamp_state_ff <= LAMP_IGNITION;
                  end
               end
               LAMP_IGNITION: begin
                  lamp_tmr_ff <= lamp_tmr_ff + 13'h0001;
                  if (lamp_tmr_ff == 13'(BPLS_IGN_HOLD_TICKS - 1)) begin
                     lamp_tmr_ff <= 13'h0000;
                     if (lamp_current_in >= BPLS_STRIKE_I_MIN && lamp_voltage_in <= BPLS_STRIKE_V_MAX) begin
                        lamp_state_ff <= LAMP_RUN_START; // RULE_18
                     end else begin
                        lamp_state_ff <= LAMP_RESTART; // RULE_18
                     end
                  end
               end
               LAMP_RESTART: begin
                  ign_fail_ff <= ign_fail_ff + 4'h1;
                  if (ign_fail_ff + 4'h1 >= BPLS_IGN_MAX_TRIES) begin
                     inv_drive_ff.pwm_run <= 1'b0; // RULE_19
                     lamp_state_ff <= LAMP_TOO_MANY;
                  end else begin
                     inv_drive_ff.half_period <= BPLS_RESTART_HP; // RULE_19
                     lamp_state_ff <= LAMP_PREHEAT;
                  end
               end
               LAMP_RUN_START: begin
                  if (inv_drive_ff.half_period > BPLS_RUN_HP) begin
                     inv_drive_ff.half_period <= inv_drive_ff.half_period - 8'h01; // RULE_20
                  end else begin
                     lamp_state_ff <= LAMP_RUN;
                  end
               end
               LAMP_RUN: begin
                  if (lamp_current_in < setpoint_ff && inv_drive_ff.half_period < BPLS_IGN_HP) begin
                     inv_drive_ff.half_period <= inv_drive_ff.half_period + 8'h01; // RULE_21
                  end else if (lamp_current_in > setpoint_ff && inv_drive_ff.half_period > BPLS_PREHEAT_HP) begin
                     inv_drive_ff.half_period <= inv_drive_ff.half_period - 8'h01; // RULE_21
                  end
               end
               LAMP_TOO_MANY: begin
                  inv_drive_ff <= '0;
                  if (conv_state_ff == CONV_OFF) begin
                     lamp_state_ff <= LAMP_OFF;
                  end
               end
               default: lamp_state_ff <= LAMP_OFF;
            endcase
         end
      end
   end
   assign inv_drive_out = inv_drive_ff;

   // Too-many-tries flag; setting wins over the clear by a new lamp-on request
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         too_many_ff <= 1'b0;
      end else if (lamp_tick && lamp_state_ff == LAMP_RESTART && ign_fail_ff + 4'h1 >= BPLS_IGN_MAX_TRIES) begin
         too_many_ff <= 1'b1; // RULE_22
      end else if (wr_setpoint && reg_wdata_in[9:0] != 10'h000) begin
         too_many_ff <= 1'b0;
      end
   end
   assign too_many_tries_out = too_many_ff;

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   off_idle_a: assert property ((conv_state_ff == CONV_OFF && !lamp_on_req_ff && !shut_req) |=> // RULE_01
      conv_state_ff == CONV_OFF) else $error("converter left off without a request");
   init_step_a: assert property ((conv_state_ff == CONV_INIT && conv_tick && !shut_req) |=> // RULE_02
      conv_state_ff == CONV_INIT_CHECK) else $error("init did not advance");
   peak_window_a: assert property ((conv_state_ff == CONV_CHECK && conv_tick && !shut_req) |=> // RULE_04
      (conv_state_ff == CONV_SS_CFG) == ($past(peak_ff) >= $past(peak_min_ff) && $past(peak_ff) <= $past(peak_max_ff)))
      else $error("peak check took the wrong branch");
   launch_limit_a: assert property ((conv_state_ff == CONV_SS_LAUNCH && conv_tick && !shut_req &&  // RULE_06
      conv_tries_ff >= BPLS_CONV_MAX_TRIES) |=> conv_state_ff == CONV_PROBLEM && !conv_drive_ff.pwm_run)
      else $error("launch ignored the try limit");
   no_zc_retry_a: assert property ((conv_state_ff == CONV_SPEED_UP && conv_tick && !shut_req && !zc_seen_ff && // RULE_09
      !zero_cross_in) |=> conv_state_ff == CONV_RETRY_DELAY && !conv_drive_ff.pwm_run)
      else $error("missing zero cross not retried");
   shut_force_a: assert property (shut_req |=> conv_state_ff == CONV_SHUTDOWN) // RULE_13
      else $error("shutdown request not taken");
   shut_lowpow_a: assert property ((conv_state_ff == CONV_SHUTDOWN && conv_tick && !shut_req) |=> // RULE_12
      conv_state_ff == CONV_OFF && !conv_drive_ff.clk_nominal && !conv_drive_ff.pwm_run)
      else $error("shutdown left clock or converter running");
   lamp_wait_a: assert property ((lamp_state_ff == LAMP_OFF && conv_state_ff != CONV_CTRL_LOOP) |=> // RULE_14
      lamp_state_ff == LAMP_OFF) else $error("lamp started before control loop");
   too_many_flag_a: assert property ((lamp_state_ff == LAMP_RESTART && lamp_tick && // RULE_22
      ign_fail_ff == BPLS_IGN_MAX_TRIES - 4'h1) |=> too_many_ff) else $error("too-many flag not set");
   problem_hold_a: assert property ((conv_state_ff == CONV_PROBLEM && !shut_req) |=> // RULE_24
      conv_state_ff == CONV_PROBLEM && !conv_drive_ff.pwm_run) else $error("problem state not held");
   lamp_tick_gap_a: assert property (lamp_tick |=> !lamp_tick [*8]) // RULE_23
      else $error("lamp ticks too close");

   ctrl_loop_c: cover property (conv_state_ff == CONV_ZC_SEARCH ##1 conv_state_ff == CONV_CTRL_LOOP);
   retry_c: cover property (conv_state_ff == CONV_RETRY_DELAY ##[1:1000] conv_state_ff == CONV_SS_CFG);
   run_c: cover property (lamp_state_ff == LAMP_RUN_START ##[1:1000] lamp_state_ff == LAMP_RUN);
   too_many_c: cover property (lamp_state_ff == LAMP_RESTART ##1 lamp_state_ff == LAMP_TOO_MANY);
endmodule // bpls_sequencer
`default_nettype wire

// *** bpls_pkg.sv ***
// Package: constants, states and carriers of the ballast converter and lamp sequencer
`default_nettype none
package bpls_pkg;
   localparam int unsigned BPLS_CLK_KHZ = 20000;
   localparam int unsigned BPLS_LAMP_TICK_US = 200;
   localparam int unsigned BPLS_CONV_FAST_TICK_US = 200;
   localparam int unsigned BPLS_CONV_SLOW_TICK_US = 1000;
   localparam int unsigned BPLS_LAMP_TICK_CYC = BPLS_CLK_KHZ * BPLS_LAMP_TICK_US / 1000;
   localparam int unsigned BPLS_CONV_FAST_CYC = BPLS_CLK_KHZ * BPLS_CONV_FAST_TICK_US / 1000;
   localparam int unsigned BPLS_CONV_SLOW_CYC = BPLS_CLK_KHZ * BPLS_CONV_SLOW_TICK_US / 1000;
   localparam int unsigned BPLS_IGN_HOLD_MS = 10;
   localparam int unsigned BPLS_IGN_HOLD_TICKS = BPLS_IGN_HOLD_MS * 1000 / BPLS_LAMP_TICK_US;
   localparam int unsigned BPLS_PREHEAT_MS = 1000;
   localparam int unsigned BPLS_PREHEAT_TICKS = BPLS_PREHEAT_MS * 1000 / BPLS_LAMP_TICK_US;
   localparam int unsigned BPLS_PREHEAT_KHZ = 80;
   localparam logic [7:0] BPLS_PREHEAT_HP = 8'(BPLS_CLK_KHZ / (2 * BPLS_PREHEAT_KHZ));
   localparam logic [7:0] BPLS_IGN_HP = 8'hC8;
   localparam logic [7:0] BPLS_RESTART_HP = 8'h82;
   localparam logic [7:0] BPLS_RUN_HP = 8'hA0;
   localparam logic [7:0] BPLS_MEASURE_TICKS = 8'h14;
   localparam logic [7:0] BPLS_RETRY_DELAY = 8'h0A;
   localparam logic [7:0] BPLS_RETRY_MULT = 8'h04;
   localparam logic [3:0] BPLS_CONV_MAX_TRIES = 4'h5;
   localparam logic [3:0] BPLS_IGN_MAX_TRIES = 4'h3;
   localparam logic [7:0] BPLS_MAX_PW = 8'h40;
   localparam logic [9:0] BPLS_STRIKE_I_MIN = 10'h040;
   localparam logic [9:0] BPLS_STRIKE_V_MAX = 10'h200;
   localparam logic [9:0] BPLS_PEAK_MIN_RST = 10'h0A0;
   localparam logic [9:0] BPLS_PEAK_MAX_RST = 10'h1D8;
   localparam logic [7:0] BPLS_REG_SETPOINT = 8'h00;
   localparam logic [7:0] BPLS_REG_COMMAND = 8'h04;
   localparam logic [7:0] BPLS_REG_PEAK_MIN = 8'h08;
   localparam logic [7:0] BPLS_REG_PEAK_MAX = 8'h0C;
   localparam logic [7:0] BPLS_REG_STATUS = 8'h10;
   localparam logic [7:0] BPLS_REG_PEAK = 8'h14;
   localparam int unsigned BPLS_CMD_SHUTDOWN_BIT = 0;
   localparam int unsigned BPLS_ST_CONV_LSB = 0;
   localparam int unsigned BPLS_ST_LAMP_LSB = 4;
   localparam int unsigned BPLS_ST_TOO_MANY_BIT = 8;
   localparam int unsigned BPLS_ST_NOMINAL_BIT = 9;
   localparam int unsigned BPLS_ST_TRIES_LSB = 12;

   typedef enum logic [3:0] {
      CONV_OFF, CONV_INIT, CONV_INIT_CHECK, CONV_MEASURE, CONV_CHECK, CONV_SS_CFG, CONV_SS_LAUNCH,
      CONV_SOFT_START, CONV_SPEED_UP, CONV_RETRY_DELAY, CONV_ZC_SEARCH, CONV_CTRL_LOOP, CONV_PROBLEM,
      CONV_SHUTDOWN
   } bpls_conv_e;

   typedef enum logic [3:0] {
      LAMP_OFF, LAMP_PRE_CFG, LAMP_PREHEAT, LAMP_IGN_START, LAMP_IGNITION, LAMP_RESTART,
      LAMP_RUN_START, LAMP_RUN, LAMP_TOO_MANY
   } bpls_lamp_e;

   typedef struct packed {
      logic pwm_run;
      logic softstart_cfg;
      logic comparator_en;
      logic clk_nominal;
      logic [7:0] max_pulse;
   } bpls_conv_drive_s;

   typedef struct packed {
      logic sense_amp_en;
      logic pwm_run;
      logic [7:0] half_period;
   } bpls_inv_drive_s;
endpackage
`default_nettype wire

// *** bpls_stage_model.sv ***
// Power stage and mains model: zero-cross pulses and lamp feedback
`timescale 1ns/1ps
`default_nettype none
module bpls_stage_model
   import bpls_pkg::*;
(
   input wire logic clk_in,
   input wire logic zc_en_in,
   input wire logic strike_in,
   input wire bpls_inv_drive_s inv_in,
   output logic zero_cross_out,
   output logic [9:0] lamp_i_out,
   output logic [9:0] lamp_v_out
);
   logic [3:0] div_ff = 4'h0;
   logic lit;
   always_ff @(posedge clk_in) begin
      div_ff <= div_ff + 4'h1;
   end
   // One-cycle crossing pulses while the mains is present
   assign zero_cross_out = zc_en_in && (div_ff == 4'hF);
   // A struck lamp draws current at low voltage
   assign lit = strike_in && inv_in.pwm_run;
   assign lamp_i_out = lit ? 10'h080 : 10'h000;
   assign lamp_v_out = lit ? 10'h100 : 10'h300;
endmodule // bpls_stage_model
`default_nettype wire

// *** tb_top.sv ***
// Testbench: register-driven sequencing of converter and lamp
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import bpls_pkg::*;
;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic [9:0] peak_sample_in = 10'h050;
   logic zero_cross_in;
   logic [9:0] lamp_current_in;
   logic [9:0] lamp_voltage_in;
   bpls_conv_drive_s conv_drive_out;
   bpls_inv_drive_s inv_drive_out;
   logic too_many_tries_out;
   logic zc_en = 1'b0;
   logic strike = 1'b0;
   logic [31:0] rv;
   logic [31:0] rst_exp [7] = '{32'h0, 32'h0, 32'h0A0, 32'h1D8, 32'h0, 32'h0, 32'h0};
   time t0;
   int errors = 0;
   int tests_run = 0;
   always #25 clk_in = ~clk_in;
   bpls_sequencer #(.CONV_SLOW_CYC(20), .CONV_FAST_CYC(8), .LAMP_TICK_CYC(10), .PREHEAT_TICKS(20))
   uut (.clk_in, .sys_rst_in,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .peak_sample_in, .zero_cross_in,
      .lamp_current_in, .lamp_voltage_in, .conv_drive_out, .inv_drive_out, .too_many_tries_out);
   bpls_stage_model stage (.clk_in(clk_in), .zc_en_in(zc_en), .strike_in(strike), .inv_in(inv_drive_out),
      .zero_cross_out(zero_cross_in), .lamp_i_out(lamp_current_in), .lamp_v_out(lamp_voltage_in));
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 rv = reg_rdata_out;
   endtask
   // Polls a status field until it holds val, at most bound + 1 reads
   task automatic wait_on(input int lsb, input logic [3:0] val, input int bound);
      int n;
      n = 0;
      rd(BPLS_REG_STATUS);
      while (rv[lsb +: 4] !== val) begin
         n++;
         if (n > bound) begin
            errors++;
            $display("unexpected at %0t: status wait ran out", $time);
            break;
         end
         rd(BPLS_REG_STATUS);
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         rd(8'(4 * k));
         check(rv, rst_exp[k]);
      end
      check(32'(conv_drive_out), 32'h0);
      wr(BPLS_REG_SETPOINT, 32'h100);
      wait_on(BPLS_ST_CONV_LSB, CONV_CHECK, 400);
      wait_on(BPLS_ST_CONV_LSB, CONV_INIT_CHECK, 40);
      rd(BPLS_REG_PEAK);
      check(rv, 32'h050);
      @(posedge clk_in) peak_sample_in <= 10'h100;
      wait_on(BPLS_ST_CONV_LSB, CONV_RETRY_DELAY, 1000);
      t0 = $time;
      check(32'(rv[15:12]), 32'h1);
      check(32'(conv_drive_out.max_pulse), 32'(BPLS_MAX_PW));
      check(32'(conv_drive_out.clk_nominal), 32'h0);
      wait_on(BPLS_ST_CONV_LSB, CONV_SS_CFG, 600);
      check(32'(($time - t0 + 500) / 1000), 32'd40);
      wait_on(BPLS_ST_CONV_LSB, CONV_PROBLEM, 3000);
      check(32'(rv[15:12]), 32'(BPLS_CONV_MAX_TRIES));
      repeat (100) @(posedge clk_in);
      rd(BPLS_REG_STATUS);
      check(32'(rv[3:0]), 32'(CONV_PROBLEM));
      check(32'(conv_drive_out.pwm_run), 32'h0);
      wr(BPLS_REG_COMMAND, 32'h1);
      wait_on(BPLS_ST_CONV_LSB, CONV_OFF, 40);
      zc_en <= 1'b1;
      wr(BPLS_REG_SETPOINT, 32'h100);
      wait_on(BPLS_ST_CONV_LSB, CONV_CTRL_LOOP, 600);
      check(32'(rv[BPLS_ST_NOMINAL_BIT]), 32'h1);
      check(32'(conv_drive_out.pwm_run), 32'h1);
      wait_on(BPLS_ST_LAMP_LSB, LAMP_PREHEAT, 100);
      check(32'(inv_drive_out.half_period), 32'(BPLS_PREHEAT_HP));
      check(32'(inv_drive_out.sense_amp_en), 32'h1);
      wait_on(BPLS_ST_LAMP_LSB, LAMP_TOO_MANY, 3000);
      check(32'(rv[BPLS_ST_TOO_MANY_BIT]), 32'h1);
      check(32'({too_many_tries_out, inv_drive_out.pwm_run}), 32'h2);
      wr(BPLS_REG_COMMAND, 32'h1);
      wait_on(BPLS_ST_LAMP_LSB, LAMP_OFF, 40);
      strike <= 1'b1;
      wr(BPLS_REG_SETPOINT, 32'h100);
      wait_on(BPLS_ST_LAMP_LSB, LAMP_RUN, 2000);
      repeat (600) @(posedge clk_in);
      check(32'(inv_drive_out.half_period), 32'(BPLS_IGN_HP));
      check(32'(too_many_tries_out), 32'h0);
      wr(BPLS_REG_SETPOINT, 32'h0);
      wait_on(BPLS_ST_LAMP_LSB, LAMP_OFF, 40);
      check(32'(rv[3:0]), 32'(CONV_CTRL_LOOP));
      wr(BPLS_REG_COMMAND, 32'h1);
      wait_on(BPLS_ST_CONV_LSB, CONV_OFF, 40);
      check(32'({conv_drive_out.pwm_run, conv_drive_out.clk_nominal}), 32'h0);
      repeat (200) @(posedge clk_in);
      rd(BPLS_REG_STATUS);
      check(32'(rv[3:0]), 32'h0);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
